// ### tx_packet_framer.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
// Overview of operation
// - Flags between frames counted by four-bit gap code in the control register.
// - Gap flag count is two to the gap code, one up to 32768, plus at least one flag in the start wait.
// - Next frame starts on a whole packet or level above start field times 16.
// - Space-available goes high when FIFO level is below low mark.
// - Space-available goes low above high mark; holds between the marks.
// - 32-bit count of sent bytes, aborted frames excluded.
// - Byte-count write snapshots and restarts counter at the amount counted that cycle, or zero.
// - Snapshot values valid within three clock cycles of the write.
// - Snapshot bit in channel monitor register triggers same transfer.
// - Counters saturate; software snapshots about once a second.
// - Packets of 64k bytes or more do not advance the byte count.
// - 24-bit frame count, aborted frames excluded, low byte readable.
module tx_packet_framer #(
  parameter int FIFO_DEPTH = tx_framer_pkg::FIFO_BYTES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Packet writer side
  input wire logic pktValid,
  output logic pktReady,
  input wire logic pktSop,
  input wire logic pktEop,
  input wire logic pktAbort,
  input wire logic [7:0] pktData,
  output logic packet_space_avail,
  // Line side, one byte per enabled cycle
  input wire logic lineReady,
  output logic lineValid,
  output logic [7:0] lineData,
  output logic lineFlag
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  typedef enum logic [1:0] {ST_GAP, ST_WAIT, ST_DATA} tx_state_e;

  tx_framer_pkg::reg_req_s req;
  tx_framer_pkg::pkt_byte_s inByte;
  tx_framer_pkg::pkt_byte_s outByte;
  tx_state_e state;
  logic [7:0] ctrl;
  logic [7:0] space_low_mark;
  logic [7:0] space_high_mark;
  logic [LW-1:0] level;
  logic outValid;
  logic outReady;
  logic [15:0] gapLeft;
  logic [LW-1:0] eopStored;
  logic eopIn;
  logic eopOut;
  logic [16:0] pktLen;
  logic [31:0] frameBytes;
  logic frameDone;
  logic snapshot;
  logic [31:0] byteSnap;
  logic [23:0] frameSnap;
  logic [3:0] gapCode;
  logic [3:0] startLevel;

  assign req = '{wr: regWr, rd: regRd, addr: regAddr, wdata: regWdata};
  assign inByte = '{sop: pktSop, eop: pktEop, abort: pktAbort, data: pktData};
  assign gapCode = ctrl[tx_framer_pkg::GAP_CODE_LSB +: 4];
  assign startLevel = ctrl[tx_framer_pkg::START_LEVEL_LSB +: 4];

  // ----------------------------------------------------------------
  // Transmit FIFO
  // ----------------------------------------------------------------
  // No flush source lives in this block, so the FIFO is never emptied early
  pkt_fifo #(
    .WIDTH($bits(tx_framer_pkg::pkt_byte_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .flush(1'b0),
    .inValid(pktValid),
    .inReady(pktReady),
    .inData(inByte),
    .outValid(outValid),
    .outReady(outReady),
    .outData(outByte),
    .level(level)
  );

  // Whole packets buffered, so the start test can see a complete one
  assign eopIn = pktValid && pktReady && pktEop;
  assign eopOut = outValid && outReady && outByte.eop;
  // Sized like the level: a FIFO full of one-byte packets holds DEPTH ends
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      eopStored <= '0;
    end else begin
      eopStored <= eopStored + LW'(eopIn) - LW'(eopOut);
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= tx_framer_pkg::FRAMER_CTRL_RESET;
      space_low_mark <= tx_framer_pkg::SPACE_LOW_MARK_RESET;
      space_high_mark <= tx_framer_pkg::SPACE_HIGH_MARK_RESET;
    end else if (req.wr) begin
      // Marks are stored whole; keeping them in range is left to software
      if (req.addr == tx_framer_pkg::FRAMER_CTRL_ADDR) begin
        ctrl <= req.wdata;
      end else if (req.addr == tx_framer_pkg::SPACE_LOW_MARK_ADDR) begin
        space_low_mark <= req.wdata;
      end else if (req.addr == tx_framer_pkg::SPACE_HIGH_MARK_ADDR) begin
        space_high_mark <= req.wdata;
      end
    end
  end

  // Combinational, so both counters copy in the very cycle of the write
  // Any write to a byte-count or frame-count register, or the monitor snapshot bit
  always_comb begin
    snapshot = 1'b0;
    if (req.wr && req.addr >= tx_framer_pkg::SENT_BYTE_B0_ADDR &&
        req.addr <= tx_framer_pkg::SENT_BYTE_B3_ADDR) begin
      snapshot = 1'b1;
    end else if (req.wr && req.addr == tx_framer_pkg::SENT_FRAME_B0_ADDR) begin
      snapshot = 1'b1;
    end else if (req.wr && req.addr == tx_framer_pkg::CHAN_MON_ADDR &&
                 req.wdata[tx_framer_pkg::SNAPSHOT_BIT]) begin
      snapshot = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register reads, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= '0;
    end else if (req.rd) begin
      // Counters are readable only as snapshot copies, so the four bytes always agree
      if (req.addr == tx_framer_pkg::FRAMER_CTRL_ADDR) begin
        regRdata <= ctrl;
      end else if (req.addr == tx_framer_pkg::SPACE_LOW_MARK_ADDR) begin
        regRdata <= space_low_mark;
      end else if (req.addr == tx_framer_pkg::SPACE_HIGH_MARK_ADDR) begin
        regRdata <= space_high_mark;
      end else if (req.addr == tx_framer_pkg::SENT_BYTE_B0_ADDR) begin
        regRdata <= byteSnap[7:0];
      end else if (req.addr == tx_framer_pkg::SENT_BYTE_B1_ADDR) begin
        regRdata <= byteSnap[15:8];
      end else if (req.addr == tx_framer_pkg::SENT_BYTE_B2_ADDR) begin
        regRdata <= byteSnap[23:16];
      end else if (req.addr == tx_framer_pkg::SENT_BYTE_B3_ADDR) begin
        regRdata <= byteSnap[31:24];
      end else if (req.addr == tx_framer_pkg::SENT_FRAME_B0_ADDR) begin
        regRdata <= frameSnap[7:0];
      end else begin
        regRdata <= '0; // Unmapped reads as zero
      end
    end
  end

  // ----------------------------------------------------------------
  // Space-available with hysteresis
  // ----------------------------------------------------------------
  // Marks compare against the byte level; between them the output holds
  // Registered: the writer sees a change one cycle after the level moves
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      packet_space_avail <= 1'b1;
    end else if (level < LW'(space_low_mark)) begin
      packet_space_avail <= 1'b1;
    end else if (level > LW'(space_high_mark)) begin
      packet_space_avail <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit sequencer: gap flags, start wait, packet data
  // ----------------------------------------------------------------
  assign outReady = (state == ST_DATA) && lineReady;
  assign frameDone = eopOut;

  // Gap length is loaded as 2**code minus one, counted down per flag
  // The gap is a minimum: the start wait after it also idles in flags,
  // so a frame follows at least one flag later than the code asks for
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_GAP;
      gapLeft <= '0;
    end else begin
      case (state)
        ST_GAP: begin
          if (lineReady) begin
            if (gapLeft == '0) begin
              state <= ST_WAIT;
            end else begin
              gapLeft <= gapLeft - 1'b1;
            end
          end
        end
        ST_WAIT: begin
          // Threshold avoids underrun inside long packets
          if (eopStored != '0 ||
              level > LW'(startLevel) * LW'(tx_framer_pkg::START_LEVEL_STEP)) begin
            state <= ST_DATA;
          end
        end
        default: begin
          // Data: leave as the end-of-packet byte is taken
          if (frameDone) begin
            state <= ST_GAP;
            gapLeft <= 16'((17'h1 << gapCode) - 17'h1);
          end
        end
      endcase
    end
  end

  // Line output: flags outside data, FIFO bytes inside
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lineValid <= 1'b0;
      lineData <= tx_framer_pkg::FLAG_CHAR;
      lineFlag <= 1'b1;
    end else if (outReady && outValid) begin
      lineValid <= 1'b1;
      lineData <= outByte.data;
      lineFlag <= 1'b0;
    end else if (state == ST_DATA) begin
      // Underrun inside a frame: send nothing, a flag here would end the frame
      lineValid <= 1'b0;
      lineData <= tx_framer_pkg::FLAG_CHAR;
      lineFlag <= 1'b1;
    end else begin
      // Gap and start wait both idle the line with flags
      lineValid <= lineReady;
      lineData <= tx_framer_pkg::FLAG_CHAR;
      lineFlag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Frame byte tally, credited at the end of a good frame
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pktLen <= '0;
    end else if (outValid && outReady) begin
      if (outByte.eop) begin
        pktLen <= '0;
      end else if (!pktLen[16]) begin
        pktLen <= pktLen + 1'b1; // Sticks once the length reaches 64k
      end
    end
  end

  // Oversize or aborted frames add nothing
  // Crediting at the end needs no undo path when a frame is cut
  always_comb begin
    frameBytes = 32'(pktLen) + 32'h1;
    if (outByte.abort || frameBytes >= 32'(tx_framer_pkg::LONG_PACKET_BYTES)) begin
      frameBytes = '0;
    end
  end

  // One snapshot strobe serves both counters, so they cover one interval
  snap_counter #(
    .WIDTH(32)
  ) u_byte_count (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .countEvent(frameDone && frameBytes != '0),
    .countAmount(frameBytes),
    .snapshot(snapshot),
    .snapValue(byteSnap)
  );

  // Frame count: only its low byte is mapped here
  snap_counter #(
    .WIDTH(24)
  ) u_frame_count (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .countEvent(frameDone && !outByte.abort),
    .countAmount(24'h1),
    .snapshot(snapshot),
    .snapValue(frameSnap)
  );

endmodule // tx_packet_framer

// ### tx_framer_pkg.sv
package tx_framer_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets on the 8-bit register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] CHAN_MON_ADDR = 8'h05;
  localparam logic [7:0] FRAMER_CTRL_ADDR = 8'hc2;
  localparam logic [7:0] SPACE_LOW_MARK_ADDR = 8'hc3;
  localparam logic [7:0] SPACE_HIGH_MARK_ADDR = 8'hc4;
  localparam logic [7:0] SENT_BYTE_B0_ADDR = 8'hc5;
  localparam logic [7:0] SENT_BYTE_B1_ADDR = 8'hc6;
  localparam logic [7:0] SENT_BYTE_B2_ADDR = 8'hc7;
  localparam logic [7:0] SENT_BYTE_B3_ADDR = 8'hc8;
  localparam logic [7:0] SENT_FRAME_B0_ADDR = 8'hc9;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int GAP_CODE_LSB = 4;
  localparam int START_LEVEL_LSB = 0;
  localparam int SNAPSHOT_BIT = 0;
  localparam logic [7:0] FRAMER_CTRL_RESET = 8'h24;
  localparam logic [7:0] SPACE_LOW_MARK_RESET = 8'h40;
  localparam logic [7:0] SPACE_HIGH_MARK_RESET = 8'hf8;

  // ----------------------------------------------------------------
  // Timing and sizes
  // ----------------------------------------------------------------
  localparam int FIFO_BYTES = 256;
  localparam int START_LEVEL_STEP = 16;
  localparam int SNAPSHOT_VALID_CYCLES = 3;
  localparam logic [16:0] LONG_PACKET_BYTES = 17'h10000;
  localparam logic [7:0] FLAG_CHAR = 8'h7e;

  // Byte of packet data with its frame marks
  typedef struct packed {
    logic sop;
    logic eop;
    logic abort;
    logic [7:0] data;
  } pkt_byte_s;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage

// ### pkt_fifo.sv
`timescale 1ns/1ps
module pkt_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 256
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic doWrite;
  logic doRead;

  // Flush blocks writes so a reset FIFO stays empty
  assign inReady = (level != (AW+1)'(DEPTH)) && !flush;
  assign outValid = (level != '0);
  assign outData = mem[rdPtr];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady && !flush;

  // Storage is plain flops, no reset needed
  always_ff @(posedge clk_sys) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else if (flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= rdPtr + 1'b1;
      end
      level <= level + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
endmodule // pkt_fifo

// ### snap_counter.sv
`timescale 1ns/1ps
module snap_counter #(
  parameter int WIDTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic countEvent,
  input wire logic [WIDTH-1:0] countAmount,
  input wire logic snapshot,
  output logic [WIDTH-1:0] snapValue
);
  logic [WIDTH-1:0] live;
  logic [WIDTH:0] sum;

  // Saturating add; sticks at all ones rather than wrapping
  assign sum = {1'b0, live} + {1'b0, countAmount};

  // Live counter restarts at the amount just counted on a snapshot
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      live <= '0;
    end else if (snapshot) begin
      live <= countEvent ? countAmount : '0;
    end else if (countEvent) begin
      live <= sum[WIDTH] ? '1 : sum[WIDTH-1:0];
    end
  end

  // Snapshot copy, valid one cycle after the write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      snapValue <= '0;
    end else if (snapshot) begin
      snapValue <= live;
    end
  end
endmodule // snap_counter

// ### tx_packet_framer_props.sv
`timescale 1ns/1ps
// ------------------------------------------------
// Port checker of the transmit framer
// ------------------------------------------------
module tx_packet_framer_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic pktValid,
  input wire logic pktReady,
  input wire logic pktSop,
  input wire logic pktEop,
  input wire logic pktAbort,
  input wire logic [7:0] pktData,
  input wire logic packet_space_avail,
  input wire logic lineReady,
  input wire logic lineValid,
  input wire logic [7:0] lineData,
  input wire logic lineFlag
);
  logic [7:0] lo;
  logic [7:0] hi;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Shadow of the marks, taken whole; no range is enforced by the device
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lo <= 8'h40;
      hi <= 8'hf8;
    end else if (regWr && regAddr == 8'hc3) begin
      lo <= regWdata;
    end else if (regWr && regAddr == 8'hc4) begin
      hi <= regWdata;
    end
  end
  sequence s_rd_lo;
    regRd && regAddr == 8'hc3;
  endsequence
  sequence s_rd_hi;
    regRd && regAddr == 8'hc4;
  endsequence
  a_low_readback: assert property (s_rd_lo |=> regRdata == lo)
    else $error("low mark readback wrong");
  a_high_readback: assert property (s_rd_hi |=> regRdata == hi)
    else $error("high mark readback wrong");
  a_unmapped_zero: assert property (regRd && regAddr == 8'h10 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!regRd |=> $stable(regRdata))
    else $error("read data moved without a read");
  a_flag_value: assert property (lineValid && lineFlag |-> lineData == 8'h7e)
    else $error("flag byte has wrong value");
  a_line_answer: assert property (lineReady && lineValid && lineFlag |=> lineValid)
    else $error("line byte missing after ready");
  a_line_idle: assert property (!lineReady |=> !lineValid)
    else $error("line byte without ready");
  // A full FIFO lies far above any mark below 0xf0
  a_full_space: assert property (!pktReady && hi < 8'hf0 |-> !packet_space_avail)
    else $error("space flag high while full");
endmodule // tx_packet_framer_props
bind tx_packet_framer tx_packet_framer_props u_props (.clk_sys, .rst_n, .regAddr, .regWdata,
  .regWr, .regRd, .regRdata, .pktValid, .pktReady, .pktSop, .pktEop, .pktAbort, .pktData,
  .packet_space_avail, .lineReady, .lineValid, .lineData, .lineFlag);

// ### pkt_writer.sv
`timescale 1ns/1ps
// ------------------------------------------------
// Link-layer packet writer
// ------------------------------------------------
module pkt_writer (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [16:0] len,
  input wire logic cut,
  input wire logic slow,
  output logic busy,
  output logic pktValid,
  input wire logic pktReady,
  output logic pktSop,
  output logic pktEop,
  output logic pktAbort,
  output logic [7:0] pktData
);
  logic [16:0] left;
  logic [16:0] pos;
  logic cutFlag;
  // A byte is held until taken; slow mode idles between bytes only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      pktValid <= 1'b0;
      left <= '0;
      pos <= '0;
      cutFlag <= 1'b0;
    end else if (!busy && start) begin
      busy <= 1'b1;
      pktValid <= 1'b1;
      left <= len;
      pos <= '0;
      cutFlag <= cut;
    end else if (pktValid && pktReady) begin
      pos <= pos + 17'h1;
      busy <= pos + 17'h2 <= left;
      pktValid <= pos + 17'h2 <= left && !(slow && $urandom_range(1) == 1);
    end else if (busy) begin
      pktValid <= 1'b1;
    end
  end
  // Marks qualify only a valid byte; idle bus shows the inverse pattern
  assign pktSop = pktValid && pos == 17'h0;
  assign pktEop = pktValid && pos + 17'h1 == left;
  assign pktAbort = pktEop && cutFlag;
  assign pktData = pktValid ? pos[7:0] : ~pos[7:0];
endmodule // pkt_writer

// ### tx_packet_framer_tb.sv
`timescale 1ns/1ps
module tx_packet_framer_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic lineReady = 1'b0;
  logic start = 1'b0;
  logic [16:0] len = 17'h1;
  logic cut = 1'b0;
  logic slow = 1'b0;
  logic [7:0] regRdata, pktData, lineData, lm, hm;
  logic pktValid, pktReady, pktSop, pktEop, pktAbort, packet_space_avail;
  logic lineValid, lineFlag, busy;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  int outCnt = 0;
  int run = 0;
  int gap = 0;
  int total = 0;
  int n;
  int idx = 0;
  tx_packet_framer u_tx_packet_framer (.clk_sys, .rst_n, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .pktValid, .pktReady, .pktSop, .pktEop, .pktAbort, .pktData,
    .packet_space_avail, .lineReady, .lineValid, .lineData, .lineFlag);
  pkt_writer u_pkt_writer (.clk_sys, .rst_n, .start, .len, .cut, .slow, .busy, .pktValid,
    .pktReady, .pktSop, .pktEop, .pktAbort, .pktData);
  initial forever #4 clk_sys = ~clk_sys;
  // Line monitor: data bytes and the flag run before each frame
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (lineValid === 1'b1 && lineFlag === 1'b1) begin
      run <= run + 1;
      idx <= 0;
    end
    if (lineValid === 1'b1 && lineFlag === 1'b0) begin
      chk("line byte", 32'(idx[7:0]), 32'(lineData));
      idx <= idx + 1;
      outCnt <= outCnt + 1;
      if (run > 0) gap <= run;
      run <= 0;
    end
  end
  // Hang guard, well above the 64k frame's run time
  always @(posedge clk_sys) begin
    if (cyc == 95000) begin
      miscompares++;
      results();
    end
  end
  function automatic int credit(input logic [16:0] k, input logic c);
    return (c || k >= 17'h10000) ? 0 : int'(k);
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (e !== s) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(posedge clk_sys);
    d = regRdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string what);
    logic [7:0] d;
    rd(a, d);
    chk(what, 32'(e), 32'(d));
  endtask
  // Snapshot, then give the copy its settling time
  task automatic snap(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic rdcount(input int bytes, input int frames);
    logic [31:0] got;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      rd(8'(8'hc5 + i), d);
      got[8*i +: 8] = d;
    end
    chk("byte total", 32'(bytes), got);
    if (frames >= 0) rdc(8'hc9, 8'(frames), "frame total");
  endtask
  task automatic send(input logic [16:0] k, input logic c);
    @(posedge clk_sys);
    len <= k;
    cut <= c;
    start <= 1'b1;
    total += credit(k, c);
    @(posedge clk_sys);
    start <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 70000 && busy !== 1'b0; i++) @(posedge clk_sys);
  endtask
  // Let the line run until a long flag run shows the FIFO empty
  task automatic drain();
    lineReady <= 1'b1;
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 70000 && run < 40; i++) @(posedge clk_sys);
  endtask
  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    void'($urandom(50));
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdc(8'hc2, 8'h24, "ctrl reset");
    rdc(8'hc3, 8'h40, "low mark reset");
    rdc(8'hc4, 8'hf8, "high mark reset");
    rdc(8'h10, 8'h00, "unmapped");
    wr(8'hc7, 8'($urandom));
    rdc(8'hc7, 8'h00, "read-only byte");
    lm = 8'(8'h50 + $urandom_range(8'h60));
    hm = 8'(lm + 1 + $urandom_range(8'h10));
    wr(8'hc3, lm);
    wr(8'hc4, hm);
    rdc(8'hc3, lm, "low mark");
    rdc(8'hc4, hm, "high mark");
    // Two queued frames per gap code, gap measured on the line
    for (int c = 0; c < 6; c++) begin
      lineReady <= 1'b0;
      wr(8'hc2, {4'(c), 4'h0});
      send(17'h4, 1'b0);
      send(17'h4, 1'b0);
      drain();
      checked++;
      if (gap < (1 << c) || gap > (1 << c) + 2) begin
        miscompares++;
        $display("[FAIL] gap flags expected %0d seen %0d", 1 << c, gap);
      end
    end
    // Byte and frame totals, aborted frame left out
    snap(8'hc5, 8'h00);
    total = 0;
    for (int k = 0; k < 4; k++) begin
      slow <= k[0];
      send(17'(1 + $urandom_range(40)), k == 2);
    end
    slow <= 1'b0;
    drain();
    snap(8'hc6, 8'h00);
    rdcount(total, 3);
    total = 0;
    send(17'(1 + $urandom_range(300)), 1'b0);
    drain();
    snap(8'h05, 8'h01);
    rdcount(total, 1);
    total = 0;
    // Space flag hysteresis with the line stalled
    wr(8'hc2, 8'h21);
    wr(8'hc3, 8'h20);
    wr(8'hc4, 8'h30);
    lineReady <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("space empty", 32'h1, 32'(packet_space_avail));
    send(17'h3c, 1'b0);
    repeat (2) @(posedge clk_sys);
    chk("space above high", 32'h0, 32'(packet_space_avail));
    n = outCnt + 20;
    lineReady <= 1'b1;
    for (int i = 0; i < 500 && outCnt < n; i++) @(posedge clk_sys);
    lineReady <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("space between", 32'h0, 32'(packet_space_avail));
    drain();
    chk("space drained", 32'h1, 32'(packet_space_avail));
    // Fill until refused, then drain
    lineReady <= 1'b0;
    fork
      send(17'h12c, 1'b0);
      begin
        for (int i = 0; i < 500 && pktReady !== 1'b0; i++) @(negedge clk_sys);
        chk("ready when full", 32'h0, 32'(pktReady));
        @(posedge clk_sys);
        lineReady <= 1'b1;
      end
    join
    drain();
    snap(8'hc8, 8'($urandom));
    rdcount(total, 2);
    send(17'h10000, 1'b0);
    drain();
    snap(8'hc5, 8'h00);
    rdcount(0, -1);
    results();
  end
endmodule // tx_packet_framer_tb
